// file: logic/luvm_consts.svh
// Purpose: Offsets, field positions, reset values and timing figures of the light and UV sequencer.
// Assumes: Included by its bare name from the package user files.
// Notes:   Definitions only; offsets, masks, writable-register reset values and timing figures live here; the repeat-rate table is in the core.
`ifndef LUVM_CONSTS_SVH
`define LUVM_CONSTS_SVH

// Register offsets on the two-wire bus.
`define LUVM_ADDR_MAIN   8'h00
`define LUVM_ADDR_RATE   8'h04
`define LUVM_ADDR_GAIN   8'h05
`define LUVM_ADDR_AMB0   8'h0d
`define LUVM_ADDR_AMB1   8'h0e
`define LUVM_ADDR_AMB2   8'h0f
`define LUVM_ADDR_UV0    8'h10
`define LUVM_ADDR_UV1    8'h11
`define LUVM_ADDR_UV2    8'h12
`define LUVM_ADDR_ICFG   8'h19
`define LUVM_ADDR_PST    8'h1a
`define LUVM_ADDR_UP0    8'h21
`define LUVM_ADDR_UP1    8'h22
`define LUVM_ADDR_UP2    8'h23
`define LUVM_ADDR_LO0    8'h24
`define LUVM_ADDR_LO1    8'h25
`define LUVM_ADDR_LO2    8'h26
`define LUVM_ADDR_VAR    8'h27

// Reset values.
`define LUVM_RST_MAIN    8'h00
`define LUVM_RST_RATE    8'h22
`define LUVM_RST_GAIN    8'h01
`define LUVM_RST_ICFG    8'h10
`define LUVM_RST_PST     8'h00
`define LUVM_RST_VAR     8'h00
`define LUVM_RST_UP      20'hfffff
`define LUVM_RST_LO      20'h00000

// Writable bits; all others read as zero.
`define LUVM_MASK_MAIN   8'h0a
`define LUVM_MASK_RATE   8'h77
`define LUVM_MASK_GAIN   8'h07
`define LUVM_MASK_ICFG   8'h34
`define LUVM_MASK_PST    8'hf0
`define LUVM_MASK_VAR    8'h17

// Field positions.
`define LUVM_BIT_EN      1
`define LUVM_BIT_UVMODE  3
`define LUVM_BIT_IRQEN   2
`define LUVM_BIT_VARMODE 4
`define LUVM_SRC_UV      2'b11

// Bus address of the device and timing figures.
`define LUVM_DEV_ADDR    7'h53
`define LUVM_CLK_KHZ     10000
`define LUVM_SETTLE_MS   5
`define LUVM_UNIT_MS     25
`define LUVM_VAR_BASE    20'h00008

`endif

// file: logic/luvm_pkg.sv
// Purpose: Types shared by the light and UV sequencer.
// Assumes: Nothing beyond the constants header.
// Notes:   Numbers live in luvm_consts.svh; this package holds types only.
package luvm_pkg;
	typedef logic [19:0] luvm_result_t;
	typedef logic [2:0]  luvm_gain_t;
	typedef logic [7:0]  luvm_byte_t;
	typedef enum logic [1:0] {
		SEQ_STANDBY,
		SEQ_SETTLE,
		SEQ_WAIT,
		SEQ_CONVERT
	} luvm_seq_e;
	typedef enum logic [3:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_ACKA,
		BUS_PTR,
		BUS_ACKP,
		BUS_WDAT,
		BUS_ACKW,
		BUS_RDAT,
		BUS_RACK
	} luvm_bus_e;
endpackage

// file: logic/luvm_core.sv
// Purpose: Measurement sequencer, register file, two-wire slave and threshold interrupt of the light/UV sensor.
// Assumes: Front-end samples arrive on clk_i; bus pins are asynchronous and are filtered here.
// Notes:   Open-drain pins pull low while their enable_n output is low.
`timescale 1ns/1ps
`include "luvm_consts.svh"

module luvm_core #(
	parameter int unsigned      SETTLE_CYC = `LUVM_SETTLE_MS * `LUVM_CLK_KHZ,
	parameter int unsigned      UNIT_CYC   = `LUVM_UNIT_MS * `LUVM_CLK_KHZ,
	parameter logic [6:0]       DEV_ADDR   = `LUVM_DEV_ADDR
) (
	input  wire logic                  clk_i,
	input  wire logic                  nrst_i,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output logic                       sda_o,
	output logic                       sda_oe_n_o,
	output logic                       irq_pad_o,
	output logic                       irq_pad_oe_n_o,
	input  wire luvm_pkg::luvm_result_t ambient_sample_i,
	input  wire luvm_pkg::luvm_result_t uv_sample_i,
	output logic                       support_power_o,
	output logic                       adc_active_o,
	output logic                       measure_uv_o,
	output luvm_pkg::luvm_gain_t       gain_o
);
	import luvm_pkg::*;

	// Register file.
	luvm_byte_t   main_q, rate_q, gain_q, icfg_q, pst_q, var_q;
	luvm_result_t upper_q, lower_q, amb_q, uv_q;

	// Bus pin filtering and slave state.
	logic [2:0]   pin_sync_q [2];
	logic [1:0]   pin_f_q;
	logic         scl_f_d, sda_f_d;
	logic         scl_rise, scl_fall, bus_start, bus_stop;
	luvm_bus_e    bus_q;
	logic [3:0]   bit_cnt_q;
	luvm_byte_t   shift_q, ptr_q, tx_q, rd_byte;
	logic         sda_drv_q, to_read_q, wr_stb;

	// Sequencer state.
	luvm_seq_e    seq_q;
	logic [31:0]  tmr_q, rate_cnt_q;
	logic         pend_q, chan_q, done;
	logic [2:0]   res_sh;
	logic [31:0]  integ_cyc, period_cyc;
	luvm_result_t conv_max, conv_val;

	// Interrupt evaluation.
	luvm_result_t prev_q, eval_val, diff;
	logic [4:0]   hit_cnt_q;
	logic         irq_q, eval, hit;

	// Repeat-rate code to multiples of the 25 ms unit.
	function automatic logic [6:0] rate_mult(input logic [2:0] code);
		case (code)
			3'd0:    rate_mult = 7'd1;
			3'd1:    rate_mult = 7'd2;
			3'd2:    rate_mult = 7'd4;
			3'd3:    rate_mult = 7'd8;
			3'd4:    rate_mult = 7'd20;
			3'd5:    rate_mult = 7'd40;
			default: rate_mult = 7'd80;
		endcase
	endfunction

	// Register read decode; unmapped offsets read as zero.
	function automatic luvm_byte_t reg_rd(input luvm_byte_t a);
		case (a)
			`LUVM_ADDR_MAIN: reg_rd = main_q;
			`LUVM_ADDR_RATE: reg_rd = rate_q;
			`LUVM_ADDR_GAIN: reg_rd = gain_q;
			`LUVM_ADDR_AMB0: reg_rd = amb_q[7:0];
			`LUVM_ADDR_AMB1: reg_rd = amb_q[15:8];
			`LUVM_ADDR_AMB2: reg_rd = {4'h0, amb_q[19:16]};
			`LUVM_ADDR_UV0:  reg_rd = uv_q[7:0];
			`LUVM_ADDR_UV1:  reg_rd = uv_q[15:8];
			`LUVM_ADDR_UV2:  reg_rd = {4'h0, uv_q[19:16]};
			`LUVM_ADDR_ICFG: reg_rd = icfg_q;
			`LUVM_ADDR_PST:  reg_rd = pst_q;
			`LUVM_ADDR_UP0:  reg_rd = upper_q[7:0];
			`LUVM_ADDR_UP1:  reg_rd = upper_q[15:8];
			`LUVM_ADDR_UP2:  reg_rd = {4'h0, upper_q[19:16]};
			`LUVM_ADDR_LO0:  reg_rd = lower_q[7:0];
			`LUVM_ADDR_LO1:  reg_rd = lower_q[15:8];
			`LUVM_ADDR_LO2:  reg_rd = {4'h0, lower_q[19:16]};
			`LUVM_ADDR_VAR:  reg_rd = var_q;
			default:         reg_rd = 8'h00;
		endcase
	endfunction

	// Three-stage synchronisers for clock and data; stage one feeds only stage two.
	for (genvar g = 0; g < 2; g++) begin : g_pin
		always_ff @(posedge clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				pin_sync_q[g] <= 3'b111;
			end else begin
				pin_sync_q[g] <= {pin_sync_q[g][1:0], (g == 0) ? scl_i : sda_i};
			end
		end
		// A level counts only once stages two and three agree, which rejects single-sample glitches.
		always_ff @(posedge clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				pin_f_q[g] <= 1'b1;
			end else if (pin_sync_q[g][1] == pin_sync_q[g][2]) begin
				pin_f_q[g] <= pin_sync_q[g][2];
			end
		end
	end

	// Edge and bus-condition detection on the filtered levels.
	assign scl_f_d   = (pin_sync_q[0][1] == pin_sync_q[0][2]) ? pin_sync_q[0][2] : pin_f_q[0];
	assign sda_f_d   = (pin_sync_q[1][1] == pin_sync_q[1][2]) ? pin_sync_q[1][2] : pin_f_q[1];
	assign scl_rise  = scl_f_d & ~pin_f_q[0];
	assign scl_fall  = ~scl_f_d & pin_f_q[0];
	assign bus_start = pin_f_q[0] & scl_f_d & pin_f_q[1] & ~sda_f_d;
	assign bus_stop  = pin_f_q[0] & scl_f_d & ~pin_f_q[1] & sda_f_d;
	assign wr_stb    = (bus_q == BUS_WDAT) && scl_fall && (bit_cnt_q == 4'd8);
	assign rd_byte   = reg_rd(ptr_q);

	// Two-wire slave: bits are taken on clock rise and driven after clock fall.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bus_q     <= BUS_IDLE;
			bit_cnt_q <= 4'd0;
			shift_q   <= 8'h00;
			ptr_q     <= 8'h00;
			tx_q      <= 8'h00;
			sda_drv_q <= 1'b0;
			to_read_q <= 1'b0;
		end else if (bus_start) begin
			bus_q     <= BUS_ADDR;
			bit_cnt_q <= 4'd0;
			sda_drv_q <= 1'b0;
		end else if (bus_stop) begin
			bus_q     <= BUS_IDLE;
			sda_drv_q <= 1'b0;
		end else begin
			case (bus_q)
				BUS_ADDR, BUS_PTR, BUS_WDAT: begin
					if (scl_rise) begin
						shift_q   <= {shift_q[6:0], pin_f_q[1]};
						bit_cnt_q <= bit_cnt_q + 4'd1;
					end else if (scl_fall && bit_cnt_q == 4'd8) begin
						bit_cnt_q <= 4'd0;
						sda_drv_q <= 1'b1;
						if (bus_q == BUS_ADDR) begin
							// Another device's address: stay off the wire until the next start.
							if (shift_q[7:1] == DEV_ADDR) begin
								bus_q     <= BUS_ACKA;
								to_read_q <= shift_q[0];
							end else begin
								bus_q     <= BUS_IDLE;
								sda_drv_q <= 1'b0;
							end
						end else if (bus_q == BUS_PTR) begin
							ptr_q <= shift_q;
							bus_q <= BUS_ACKP;
						end else begin
							ptr_q <= ptr_q + 8'h01;
							bus_q <= BUS_ACKW;
						end
					end
				end
				BUS_ACKA, BUS_ACKP, BUS_ACKW: begin
					if (scl_fall) begin
						if (bus_q == BUS_ACKA && to_read_q) begin
							tx_q      <= rd_byte;
							sda_drv_q <= ~rd_byte[7];
							bus_q     <= BUS_RDAT;
						end else begin
							sda_drv_q <= 1'b0;
							bus_q     <= (bus_q == BUS_ACKA) ? BUS_PTR : BUS_WDAT;
						end
					end
				end
				BUS_RDAT: begin
					if (scl_rise) begin
						bit_cnt_q <= bit_cnt_q + 4'd1;
					end else if (scl_fall) begin
						if (bit_cnt_q == 4'd8) begin
							sda_drv_q <= 1'b0;
							ptr_q     <= ptr_q + 8'h01;
							bus_q     <= BUS_RACK;
						end else begin
							sda_drv_q <= ~tx_q[3'd7 - bit_cnt_q[2:0]];
						end
					end
				end
				BUS_RACK: begin
					// A not-acknowledge ends the read; the host follows with stop or start.
					if (scl_rise && pin_f_q[1]) begin
						bus_q <= BUS_IDLE;
					end else if (scl_fall) begin
						bit_cnt_q <= 4'd0;
						tx_q      <= rd_byte;
						sda_drv_q <= ~rd_byte[7];
						bus_q     <= BUS_RDAT;
					end
				end
				default: begin
					sda_drv_q <= 1'b0;
				end
			endcase
		end
	end

	// Host-written registers; reserved bits are dropped so they read as zero.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			main_q  <= `LUVM_RST_MAIN;
			rate_q  <= `LUVM_RST_RATE;
			gain_q  <= `LUVM_RST_GAIN;
			icfg_q  <= `LUVM_RST_ICFG;
			pst_q   <= `LUVM_RST_PST;
			var_q   <= `LUVM_RST_VAR;
			upper_q <= `LUVM_RST_UP;
			lower_q <= `LUVM_RST_LO;
		end else if (wr_stb) begin
			case (ptr_q)
				`LUVM_ADDR_MAIN: main_q <= shift_q & `LUVM_MASK_MAIN;
				`LUVM_ADDR_RATE: rate_q <= shift_q & `LUVM_MASK_RATE;
				`LUVM_ADDR_GAIN: gain_q <= shift_q & `LUVM_MASK_GAIN;
				`LUVM_ADDR_ICFG: icfg_q <= shift_q & `LUVM_MASK_ICFG;
				`LUVM_ADDR_PST:  pst_q  <= shift_q & `LUVM_MASK_PST;
				`LUVM_ADDR_VAR:  var_q  <= shift_q & `LUVM_MASK_VAR;
				`LUVM_ADDR_UP0:  upper_q[7:0]   <= shift_q;
				`LUVM_ADDR_UP1:  upper_q[15:8]  <= shift_q;
				`LUVM_ADDR_UP2:  upper_q[19:16] <= shift_q[3:0];
				`LUVM_ADDR_LO0:  lower_q[7:0]   <= shift_q;
				`LUVM_ADDR_LO1:  lower_q[15:8]  <= shift_q;
				`LUVM_ADDR_LO2:  lower_q[19:16] <= shift_q[3:0];
				default: begin
				end
			endcase
		end
	end

	// Resolution code 0..4 is 20..16 bits; larger codes behave as 16 bits.
	assign res_sh     = (rate_q[6:4] > 3'd4) ? 3'd4 : rate_q[6:4];
	assign integ_cyc  = UNIT_CYC << (3'd4 - res_sh);
	assign period_cyc = 32'(UNIT_CYC * rate_mult(rate_q[2:0]));
	assign conv_max   = `LUVM_RST_UP >> res_sh;
	assign conv_val   = chan_q ? uv_sample_i : ambient_sample_i;
	assign done       = (seq_q == SEQ_CONVERT) && (tmr_q >= integ_cyc - 32'd1);

	// Main sequencer: standby, settle, wait for a trigger, convert.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seq_q  <= SEQ_STANDBY;
			tmr_q  <= 32'd0;
			chan_q <= 1'b0;
		end else begin
			case (seq_q)
				SEQ_STANDBY: begin
					tmr_q <= 32'd0;
					if (main_q[`LUVM_BIT_EN]) begin
						seq_q <= SEQ_SETTLE;
					end
				end
				SEQ_SETTLE: begin
					tmr_q <= tmr_q + 32'd1;
					if (!main_q[`LUVM_BIT_EN]) begin
						seq_q <= SEQ_STANDBY;
					end else if (tmr_q >= SETTLE_CYC - 32'd1) begin
						seq_q <= SEQ_WAIT;
					end
				end
				SEQ_WAIT: begin
					tmr_q <= 32'd0;
					if (!main_q[`LUVM_BIT_EN]) begin
						seq_q <= SEQ_STANDBY;
					end else if (pend_q) begin
						seq_q  <= SEQ_CONVERT;
						chan_q <= main_q[`LUVM_BIT_UVMODE];
					end
				end
				SEQ_CONVERT: begin
					tmr_q <= tmr_q + 32'd1;
					// A cleared enable is honoured only once the running conversion ends.
					if (done) begin
						seq_q <= main_q[`LUVM_BIT_EN] ? SEQ_WAIT : SEQ_STANDBY;
					end
				end
				default: begin
					seq_q <= SEQ_STANDBY;
				end
			endcase
		end
	end

	// Scheduler: the first trigger is immediate, later ones follow the repeat rate.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rate_cnt_q <= 32'd0;
			pend_q     <= 1'b0;
		end else if (seq_q == SEQ_STANDBY || seq_q == SEQ_SETTLE) begin
			rate_cnt_q <= 32'd0;
			pend_q     <= 1'b1;
		end else if (rate_cnt_q >= period_cyc - 32'd1) begin
			rate_cnt_q <= 32'd0;
			pend_q     <= 1'b1;
		end else begin
			rate_cnt_q <= rate_cnt_q + 32'd1;
			if (seq_q == SEQ_WAIT && pend_q) begin
				pend_q <= 1'b0;
			end
		end
	end

	// Results change only at conversion end, all bytes at once, clipped to the resolution.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			amb_q <= 20'h00000;
			uv_q  <= 20'h00000;
		end else if (done) begin
			if (chan_q) begin
				uv_q <= (conv_val > conv_max) ? conv_max : conv_val;
			end else begin
				amb_q <= (conv_val > conv_max) ? conv_max : conv_val;
			end
		end
	end

	// Evaluation happens only when the completed channel is the selected source.
	assign eval     = done && (chan_q == (icfg_q[5:4] == `LUVM_SRC_UV));
	assign eval_val = (conv_val > conv_max) ? conv_max : conv_val;
	assign diff     = (eval_val > prev_q) ? eval_val - prev_q : prev_q - eval_val;
	assign hit      = var_q[`LUVM_BIT_VARMODE] ?
		(diff > (`LUVM_VAR_BASE << var_q[2:0])) :
		(eval_val > upper_q || eval_val < lower_q);

	// Consecutive-hit counter and level interrupt; an in-range result releases the pad.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prev_q    <= 20'h00000;
			hit_cnt_q <= 5'd0;
			irq_q     <= 1'b0;
		end else if (!icfg_q[`LUVM_BIT_IRQEN]) begin
			hit_cnt_q <= 5'd0;
			irq_q     <= 1'b0;
		end else if (eval) begin
			prev_q <= eval_val;
			if (hit) begin
				if (hit_cnt_q <= {1'b0, pst_q[7:4]}) begin
					hit_cnt_q <= hit_cnt_q + 5'd1;
				end
				if (hit_cnt_q >= {1'b0, pst_q[7:4]}) begin
					irq_q <= 1'b1;
				end
			end else begin
				hit_cnt_q <= 5'd0;
				irq_q     <= 1'b0;
			end
		end
	end

	// Pads are open drain: output low, enable_n low while pulling.
	assign sda_o           = 1'b0;
	assign sda_oe_n_o      = ~sda_drv_q;
	assign irq_pad_o       = 1'b0;
	assign irq_pad_oe_n_o  = ~irq_q;
	assign support_power_o = (seq_q != SEQ_STANDBY);
	assign adc_active_o    = (seq_q == SEQ_CONVERT);
	assign measure_uv_o    = chan_q;
	assign gain_o          = gain_q[2:0];

endmodule // luvm_core

// file: testbench/luvm_core_sva.sv
// Purpose: Concurrent checks on the sequencer, bus and pad outputs of the light and UV core.
// Assumes: One clock domain; counts shortened through the same parameters as the core.
// Notes:   Sees only the core's ports; the bind follows the module.
`timescale 1ns/1ps
module luvm_core_sva #(
	parameter int unsigned SETTLE_CYC = 20,
	parameter int unsigned UNIT_CYC   = 40
) (
	input wire logic                   clk_i,
	input wire logic                   nrst_i,
	input wire logic                   scl_i,
	input wire logic                   sda_i,
	input wire logic                   sda_o,
	input wire logic                   sda_oe_n_o,
	input wire logic                   irq_pad_o,
	input wire logic                   irq_pad_oe_n_o,
	input wire luvm_pkg::luvm_result_t ambient_sample_i,
	input wire luvm_pkg::luvm_result_t uv_sample_i,
	input wire logic                   support_power_o,
	input wire logic                   adc_active_o,
	input wire logic                   measure_uv_o,
	input wire luvm_pkg::luvm_gain_t   gain_o
);
	import luvm_pkg::*;
	int unsigned pwr_cnt_q;
	int unsigned act_cnt_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// Cycles with support circuits up; a wide counter avoids saturation logic in a short run.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) pwr_cnt_q <= 0;
		else pwr_cnt_q <= support_power_o ? pwr_cnt_q + 1 : 0;
	end
	// Cycles of the conversion in progress.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) act_cnt_q <= 0;
		else act_cnt_q <= adc_active_o ? act_cnt_q + 1 : 0;
	end
	// Converters stay quiet for the first cycles of settling.
	sequence settle_s;
		!adc_active_o [*8];
	endsequence
	power_conv_a: assert property (adc_active_o |-> support_power_o) else $error("conversion without power");
	settle_quiet_a: assert property ($rose(support_power_o) |-> settle_s) else $error("early conversion");
	settle_len_a: assert property ($rose(adc_active_o) |-> pwr_cnt_q >= SETTLE_CYC)
		else $error("settling too short");
	conv_len_a: assert property ($fell(adc_active_o) |-> act_cnt_q >= UNIT_CYC)
		else $error("conversion cut short");
	channel_hold_a: assert property (adc_active_o && $past(adc_active_o) |-> $stable(measure_uv_o))
		else $error("channel changed mid conversion");
	irq_eval_a: assert property ($fell(irq_pad_oe_n_o) |->
		$past(adc_active_o) || $past(adc_active_o, 2) || $past(adc_active_o, 3)) else $error("irq outside evaluation");
	pads_od_a: assert property (sda_o == 1'b0 && irq_pad_o == 1'b0) else $error("pad driven high");
	reset_out_a: assert property ($rose(nrst_i) |-> gain_o == 3'h1 && sda_oe_n_o && irq_pad_oe_n_o
		&& !support_power_o) else $error("bad reset outputs");
	sda_hold_a: assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*4]) else $error("data bit too short");
endmodule // luvm_core_sva

bind luvm_core luvm_core_sva #(.SETTLE_CYC(SETTLE_CYC), .UNIT_CYC(UNIT_CYC)) i_luvm_core_sva (
	.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
	.irq_pad_o(irq_pad_o), .irq_pad_oe_n_o(irq_pad_oe_n_o), .ambient_sample_i(ambient_sample_i),
	.uv_sample_i(uv_sample_i), .support_power_o(support_power_o), .adc_active_o(adc_active_o),
	.measure_uv_o(measure_uv_o), .gain_o(gain_o));

// file: testbench/luvm_host.sv
// Purpose: Host controller model on the two-wire bus of the sensor.
// Assumes: Bit slot of eight clk_i cycles; both lines pulled up.
// Notes:   Lines rest high between frames; SDA is only pulled low or released.
`timescale 1ns/1ps
`include "luvm_consts.svh"
module luvm_host (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Low phase of five cycles, high phase of three: the device moves its pull four cycles after a clock fall.
	// A shorter low phase lets that release meet the clock rise, and the device then misses a refused byte.
	task automatic bit_x(input logic b, output logic s);
		sda_o <= b;
		cyc(3);
		scl_o <= 1'b1;
		cyc(3);
		s = sda_i;
		scl_o <= 1'b0;
		cyc(2);
	endtask
	// Start condition, or repeated start from a low clock.
	task automatic start(input logic rep);
		cyc(1);
		if (rep) begin
			sda_o <= 1'b1;
			cyc(2);
			scl_o <= 1'b1;
			cyc(4);
		end
		sda_o <= 1'b0;
		cyc(4);
		scl_o <= 1'b0;
		cyc(2);
	endtask
	task automatic stop();
		sda_o <= 1'b0;
		cyc(2);
		scl_o <= 1'b1;
		cyc(4);
		sda_o <= 1'b1;
		cyc(4);
	endtask
	task automatic tx(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(d[i], s);
		bit_x(1'b1, s);
		ack = ~s;
	endtask
	task automatic rx(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, s);
			d[i] = s;
		end
		bit_x(last, s);
	endtask
	// Register write; ok only if address, pointer and data were all acknowledged.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic k0, k1, k2;
		start(1'b0);
		tx({`LUVM_DEV_ADDR, 1'b0}, k0);
		tx(a, k1);
		tx(d, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask
	// Reads n bytes from pointer a, low byte first; the last byte is refused to end the frame.
	task automatic rd(input logic [7:0] a, input int n, output logic [23:0] d);
		logic k;
		logic [7:0] b;
		d = '0;
		start(1'b0);
		tx({`LUVM_DEV_ADDR, 1'b0}, k);
		tx(a, k);
		start(1'b1);
		tx({`LUVM_DEV_ADDR, 1'b1}, k);
		for (int i = 0; i < n; i++) begin
			rx(i == n - 1, b);
			d[8*i +: 8] = b;
		end
		stop();
	endtask
endmodule // luvm_host

// file: testbench/light_uv_measure_interrupt_tb_top.sv
// Purpose: Register-level tests of the light and UV core through a bus host model.
// Assumes: Settle and unit counts shortened to 20 and 40 cycles.
// Notes:   SDA wire level is the AND of host and device pulls.
`timescale 1ns/1ps
module light_uv_measure_interrupt_tb_top;
	import luvm_pkg::*;
	logic         clk_i = 1'b0;
	logic         nrst_i = 1'b0;
	logic         host_scl, host_sda, sda_w, ok;
	logic         sda_o, sda_oe_n_o, irq_pad_o, irq_pad_oe_n_o;
	logic         support_power_o, adc_active_o, measure_uv_o;
	luvm_result_t amb_q, uv_q;
	luvm_gain_t   gain_o;
	logic [23:0]  rv;
	int           num_errors = 0;
	int           compares = 0;
	always #50 clk_i = ~clk_i;
	// Open-drain data line with pull-up.
	assign sda_w = host_sda & (sda_oe_n_o | sda_o);
	luvm_host i_luvm_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(host_scl), .sda_o(host_sda));
	luvm_core #(.SETTLE_CYC(20), .UNIT_CYC(40)) i_luvm_core (.clk_i(clk_i), .nrst_i(nrst_i),
		.scl_i(host_scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .irq_pad_o(irq_pad_o),
		.irq_pad_oe_n_o(irq_pad_oe_n_o), .ambient_sample_i(amb_q), .uv_sample_i(uv_q),
		.support_power_o(support_power_o), .adc_active_o(adc_active_o), .measure_uv_o(measure_uv_o),
		.gain_o(gain_o));
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("Compares %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		i_luvm_host.wr(a, d, ok);
		chk("ack", ok, 1'b1);
	endtask
	task automatic r(input logic [7:0] a, input int n, input logic [23:0] e, input string nm);
		i_luvm_host.rd(a, n, rv);
		chk(nm, rv, e);
	endtask
	// Bounded wait for a level of the conversion flag.
	task automatic wait_lvl(input logic v);
		int n;
		n = 0;
		while (adc_active_o !== v && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 3000) begin
			num_errors++;
			final_report();
		end
	endtask
	task automatic wait_conv();
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		repeat (3) @(posedge clk_i);
	endtask
	// Watchdog against a hung run.
	initial begin
		repeat (100000) @(posedge clk_i);
		num_errors++;
		final_report();
	end
	initial begin
		amb_q <= 20'h12345;
		uv_q <= 20'habcde;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		r(8'h00, 1, 24'h00, "main");
		r(8'h04, 1, 24'h22, "rate");
		r(8'h05, 1, 24'h01, "gain");
		r(8'h19, 1, 24'h10, "icfg");
		r(8'h1a, 1, 24'h00, "pst");
		r(8'h30, 1, 24'h00, "unmapped");
		w(8'h05, 8'h04);
		chk("gain_o", gain_o, 3'h4);
		$display("Test registers done");
		// Ambient at 16-bit resolution clips the 20-bit sample.
		w(8'h04, 8'h40);
		w(8'h00, 8'h02);
		wait_conv();
		chk("uv_mode", measure_uv_o, 1'b0);
		r(8'h0d, 3, 24'h00ffff, "amb16");
		w(8'h00, 8'h00);
		repeat (60) @(posedge clk_i);
		chk("power", support_power_o, 1'b0);
		chk("active", adc_active_o, 1'b0);
		$display("Test ambient done");
		// Ultraviolet at 20 bits, upper limit 0x0ffff, two results needed.
		w(8'h23, 8'h00);
		w(8'h1a, 8'h10);
		w(8'h19, 8'h34);
		w(8'h04, 8'h04);
		w(8'h00, 8'h0a);
		wait_conv();
		chk("irq1", irq_pad_oe_n_o, 1'b1);
		chk("uv_mode", measure_uv_o, 1'b1);
		r(8'h10, 3, 24'h0abcde, "uv20");
		wait_conv();
		chk("irq2", irq_pad_oe_n_o, 1'b0);
		uv_q <= 20'h00800;
		wait_conv();
		chk("irq_in", irq_pad_oe_n_o, 1'b1);
		uv_q <= 20'habcde;
		wait_conv();
		wait_conv();
		chk("irq3", irq_pad_oe_n_o, 1'b0);
		w(8'h19, 8'h30);
		chk("irq_off", irq_pad_oe_n_o, 1'b1);
		$display("Test uv interrupt done");
		// Ambient source ignores ultraviolet results, then fires on ambient ones.
		amb_q <= 20'hfffff;
		w(8'h19, 8'h14);
		wait_conv();
		wait_conv();
		chk("irq_src", irq_pad_oe_n_o, 1'b1);
		w(8'h00, 8'h02);
		wait_conv();
		wait_conv();
		wait_conv();
		chk("irq_amb", irq_pad_oe_n_o, 1'b0);
		$display("Test source done");
		// Variance mode: a steady value releases the pad, two large jumps in a row assert it.
		w(8'h27, 8'h10);
		wait_conv();
		chk("var_flat", irq_pad_oe_n_o, 1'b1);
		amb_q <= 20'h00000;
		wait_conv();
		chk("var_one", irq_pad_oe_n_o, 1'b1);
		amb_q <= 20'hfffff;
		wait_conv();
		chk("var_two", irq_pad_oe_n_o, 1'b0);
		$display("Test variance done");
		final_report();
	end
endmodule // light_uv_measure_interrupt_tb_top
